// >>> src/sar_ctrl_pkg.sv
package sar_ctrl_pkg;

  // ==========================================================
  // widths
  localparam int unsigned RESULT_W        = 16;
  localparam int unsigned BIT_IDX_W       = 4;

  // ==========================================================
  // timing (figures as printed, counts at core_clk rate)
  localparam int unsigned CLK_PERIOD_PS   = 10000;
  localparam int unsigned CONV_TYP_NS     = 3300;
  localparam int unsigned CONV_MAX_NS     = 3800;
  localparam int unsigned ACQ_MAX_NS      = 480;
  localparam int unsigned NAP_WAKE_NS     = 200;
  localparam int unsigned SLEEP_WAKE_MS   = 160;
  // conversion paced well inside the longest time: steps per bit decision
  localparam int unsigned CONV_CYCLES     = (CONV_TYP_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned STEP_CYCLES     = CONV_CYCLES / RESULT_W;
  localparam int unsigned ACQ_CYCLES      = (ACQ_MAX_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned NAP_WAKE_CYCLES = (NAP_WAKE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned STEP_CNT_W      = 8;

  // ==========================================================
  // reset values
  localparam logic [15:0] RESULT_RST      = 16'h0000;

  // ==========================================================
  // state machine
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_CLEAR   = 2'b01,
    ST_DECIDE  = 2'b11,
    ST_LOAD    = 2'b10
  } conv_state_e;

  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'b00,
    PWR_NAP    = 2'b01,
    PWR_SLEEP  = 2'b11
  } pwr_mode_e;

  // host side control pins, all active low
  typedef struct packed {
    logic chip_sel_n;
    logic read_n;
    logic conv_start_n;
    logic power_down_n;
  } host_ctrl_s;

  // three-state data bus
  typedef struct packed {
    logic [RESULT_W-1:0] data;
    logic                oe;
  } result_bus_s;

endpackage : sar_ctrl_pkg

// >>> src/sar_adc_parallel_control.sv
// Functional notes
// - start a conversion on conv_start_n falling edge while chip select low.
// - ignore start and read while chip select is high.
// - a running conversion cannot be restarted by further start edges.
// - clear the approximation register at the start of every conversion.
// - resolve sixteen bits one per step, most significant first.
// - after the last decision load the register into output latches.
// - busy_n low throughout a conversion, high otherwise.
// - new result on the data outputs by the rising edge of busy_n.
// - drive data only while read and chip select are both low.
// - sixteen outputs, bit fifteen is the most significant.
// - result is two's complement of the positive minus negative input.
// - conversion paced internally, typically 3.3 us, at most 3.8 us.
// - acquisition within 480 ns, supporting at least 250 ksps.
// - power_down_n low gives nap with chip select low, else sleep.
// - nap keeps logic powered; host waits 200 ns after nap ends.
// - seen as memory mapped peripheral with separate start input.
// - latches keep the previous result until the new one loads.
module sar_adc_parallel_control #(
  parameter int unsigned RES_W      = sar_ctrl_pkg::RESULT_W,
  parameter int unsigned STEP_CYC   = sar_ctrl_pkg::STEP_CYCLES,
  parameter int unsigned ACQ_CYC    = sar_ctrl_pkg::ACQ_CYCLES,
  parameter int unsigned WAKE_CYC   = sar_ctrl_pkg::NAP_WAKE_CYCLES
) (
  input  wire logic                           core_clk,
  input  wire logic                           rst_n,
  input  wire logic                           clk_en,
  input  wire sar_ctrl_pkg::host_ctrl_s       host_pins,
  input  wire logic                           comp_out,
  output logic                                sample_hold,
  output logic [RES_W-1:0]                    dac_code,
  output logic                                busy_n,
  output logic [RES_W-1:0]                    result_bus,
  output logic                                result_bus_oe,
  output sar_ctrl_pkg::pwr_mode_e             pwr_mode,
  output logic                                wake_ready
);
  import sar_ctrl_pkg::*;

  // ==========================================================
  // input synchronisers
  host_ctrl_s sync1_ff, sync2_ff, nxt_sync1, nxt_sync2;
  logic       comp1_ff, comp2_ff, nxt_comp1, nxt_comp2;
  logic       start_prev_ff, nxt_start_prev;

  always_comb begin
    nxt_sync1      = host_pins;
    nxt_sync2      = sync1_ff;
    nxt_comp1      = comp_out;
    nxt_comp2      = comp1_ff;
    nxt_start_prev = sync2_ff.conv_start_n;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sync1_ff      <= '1;
      sync2_ff      <= '1;
      comp1_ff      <= 1'b0;
      comp2_ff      <= 1'b0;
      start_prev_ff <= 1'b1;
    end else if (clk_en) begin
      sync1_ff      <= nxt_sync1;
      sync2_ff      <= nxt_sync2;
      comp1_ff      <= nxt_comp1;
      comp2_ff      <= nxt_comp2;
      start_prev_ff <= nxt_start_prev;
    end
  end

  logic selected;
  logic start_fall;
  assign selected   = !sync2_ff.chip_sel_n;
  assign start_fall = start_prev_ff && !sync2_ff.conv_start_n;

  // ==========================================================
  // power modes
  pwr_mode_e                pwr_ff, nxt_pwr;
  logic [STEP_CNT_W-1:0]    wake_cnt_ff, nxt_wake_cnt;

  always_comb begin
    nxt_pwr      = PWR_ACTIVE;
    nxt_wake_cnt = wake_cnt_ff;
    if (!sync2_ff.power_down_n) begin
      nxt_pwr      = selected ? PWR_NAP : PWR_SLEEP;
      nxt_wake_cnt = '0;
    end else if (wake_cnt_ff < STEP_CNT_W'(WAKE_CYC)) begin
      nxt_wake_cnt = wake_cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pwr_ff      <= PWR_ACTIVE;
      wake_cnt_ff <= STEP_CNT_W'(WAKE_CYC);
    end else if (clk_en) begin
      pwr_ff      <= nxt_pwr;
      wake_cnt_ff <= nxt_wake_cnt;
    end
  end

  assign pwr_mode   = pwr_ff;
  assign wake_ready = (pwr_ff == PWR_ACTIVE) && (wake_cnt_ff == STEP_CNT_W'(WAKE_CYC));

  // ==========================================================
  // conversion sequencer
  conv_state_e              state_ff, nxt_state;
  logic [RES_W-1:0]         approx_register_ff, nxt_approx_register;
  logic [RES_W-1:0]         latch_ff, nxt_latch;
  logic [BIT_IDX_W-1:0]     bit_ff, nxt_bit;
  logic [STEP_CNT_W-1:0]    step_ff, nxt_step;
  logic                     acq_ff, nxt_acq;
  logic [STEP_CNT_W-1:0]    acq_cnt_ff, nxt_acq_cnt;

  always_comb begin
    nxt_state           = state_ff;
    nxt_approx_register = approx_register_ff;
    nxt_latch           = latch_ff;
    nxt_bit             = bit_ff;
    nxt_step            = step_ff;
    nxt_acq             = acq_ff;
    nxt_acq_cnt         = acq_cnt_ff;
    case (state_ff)
      ST_IDLE: begin
        // track input after the last conversion
        if (acq_cnt_ff < STEP_CNT_W'(ACQ_CYC)) begin
          nxt_acq_cnt = acq_cnt_ff + 1'b1;
        end
        if (start_fall && selected && pwr_ff == PWR_ACTIVE) begin
          nxt_state = ST_CLEAR;
          nxt_acq   = 1'b0;
        end
      end
      ST_CLEAR: begin
        nxt_approx_register = '0;
        nxt_approx_register[RES_W-1] = 1'b1;
        nxt_bit             = BIT_IDX_W'(RES_W - 1);
        nxt_step            = '0;
        nxt_state           = ST_DECIDE;
      end
      ST_DECIDE: begin
        // start edges have no effect here
        if (step_ff == STEP_CNT_W'(STEP_CYC - 1)) begin
          nxt_step = '0;
          // register and dac stay offset binary; sign flips at load
          nxt_approx_register[bit_ff] = comp2_ff;
          if (bit_ff == '0) begin
            nxt_state = ST_LOAD;
          end else begin
            nxt_bit = bit_ff - 1'b1;
            nxt_approx_register[bit_ff - 1'b1] = 1'b1;
          end
        end else begin
          nxt_step = step_ff + 1'b1;
        end
      end
      ST_LOAD: begin
        nxt_latch   = approx_register_ff ^ {1'b1, {(RES_W-1){1'b0}}};
        nxt_acq     = 1'b1;
        nxt_acq_cnt = '0;
        nxt_state   = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_ff           <= ST_IDLE;
      approx_register_ff <= RESULT_RST;
      latch_ff           <= RESULT_RST;
      bit_ff             <= '0;
      step_ff            <= '0;
      acq_ff             <= 1'b1;
      acq_cnt_ff         <= '0;
    end else if (clk_en) begin
      state_ff           <= nxt_state;
      approx_register_ff <= nxt_approx_register;
      latch_ff           <= nxt_latch;
      bit_ff             <= nxt_bit;
      step_ff            <= nxt_step;
      acq_ff             <= nxt_acq;
      acq_cnt_ff         <= nxt_acq_cnt;
    end
  end

  // ==========================================================
  // outputs
  logic busy_ff, nxt_busy;
  logic oe_ff, nxt_oe;

  always_comb begin
    // busy_n rises on the same clock edge as the latch loads
    nxt_busy = (nxt_state != ST_IDLE);
    nxt_oe   = selected && !sync2_ff.read_n;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      busy_ff <= 1'b0;
      oe_ff   <= 1'b0;
    end else if (clk_en) begin
      busy_ff <= nxt_busy;
      oe_ff   <= nxt_oe;
    end
  end

  assign busy_n        = !busy_ff;
  assign result_bus    = latch_ff;
  assign result_bus_oe = oe_ff;
  assign sample_hold   = acq_ff;
  assign dac_code      = approx_register_ff;

endmodule : sar_adc_parallel_control

// >>> test/sar_cmp_model.sv
module sar_cmp_model (
  input  wire logic [15:0] dac_code,
  input  wire logic [15:0] level,
  output logic             comp_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // two's complement level against offset-binary trial code
  assign comp_out = (level ^ 16'h8000) >= dac_code;
endmodule : sar_cmp_model

// >>> test/sar_ctrl_props.sv
module sar_ctrl_props
  import sar_ctrl_pkg::*;
#(parameter int unsigned STEP_CYC = 20) (
  input wire logic                     core_clk,
  input wire logic                     rst_n,
  input wire sar_ctrl_pkg::host_ctrl_s host_pins,
  input wire logic [15:0]              dac_code,
  input wire logic                     busy_n,
  input wire logic [15:0]              result_bus,
  input wire logic                     result_bus_oe,
  input wire sar_ctrl_pkg::pwr_mode_e  pwr_mode,
  input wire logic                     wake_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       cs, rd, pd, cv;
  logic [9:0] low_ff, nxt_low;
  assign cs = host_pins.chip_sel_n;
  assign rd = host_pins.read_n;
  assign pd = host_pins.power_down_n;
  assign cv = host_pins.conv_start_n;
  // ==========================================
  // busy low length
  always_comb nxt_low = busy_n ? 10'h000 : low_ff + 10'h001;
  always_ff @(posedge core_clk) low_ff <= rst_n ? nxt_low : 10'h000;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_busy_len: assert property ($rose(busy_n) |-> low_ff == 16 * STEP_CYC + 2)
    else $error("busy low length wrong");
  a_start_ack: assert property ((busy_n && pwr_mode == PWR_ACTIVE && !cs && $fell(cv)) |-> ##[1:4] !busy_n)
    else $error("start not taken");
  a_start_cause: assert property ($fell(busy_n) |-> $past(!cs && pwr_mode == PWR_ACTIVE, 2))
    else $error("start taken while refused");
  a_clear_msb: assert property ($fell(busy_n) |-> ##[0:2] dac_code == 16'h8000)
    else $error("register not cleared");
  a_bus_hold: assert property (!$stable(result_bus) |-> $rose(busy_n))
    else $error("result changed outside load");
  a_oe_on: assert property ((!rd && !cs) [*4] |-> result_bus_oe)
    else $error("bus not driven");
  a_oe_off: assert property ((rd || cs) [*4] |-> !result_bus_oe)
    else $error("bus driven while not read");
  a_nap_mode: assert property ((!pd && !cs) [*5] |-> pwr_mode == PWR_NAP)
    else $error("nap not entered");
  a_sleep_mode: assert property ((!pd && cs) [*5] |-> pwr_mode == PWR_SLEEP)
    else $error("sleep not entered");
  a_wake_active: assert property (wake_ready |-> pwr_mode == PWR_ACTIVE)
    else $error("wake ready in shutdown");
  cover property ($rose(busy_n));
  cover property (pwr_mode == PWR_NAP);
  cover property ($rose(result_bus_oe));
endmodule : sar_ctrl_props

bind sar_adc_parallel_control sar_ctrl_props #(.STEP_CYC(STEP_CYC)) u_props (
  .core_clk(core_clk), .rst_n(rst_n), .host_pins(host_pins), .dac_code(dac_code), .busy_n(busy_n),
  .result_bus(result_bus), .result_bus_oe(result_bus_oe), .pwr_mode(pwr_mode), .wake_ready(wake_ready));

// >>> test/tb_sar_adc_parallel_control.sv
module tb_sar_adc_parallel_control;
  timeunit 1ns;
  timeprecision 1ps;
  import sar_ctrl_pkg::*;
  logic        core_clk, rst_n, comp_out, busy_n, oe, wake_ready, busy_q, hold;
  logic [15:0] dac_code, result_bus, level, last_res;
  logic [15:0] exp_q[$];
  logic [31:0] seed;
  host_ctrl_s  pins;
  pwr_mode_e   pwr_mode;
  int          err_total, n_checks;

  sar_adc_parallel_control #(.STEP_CYC(4)) u_dut (
    .core_clk(core_clk), .rst_n(rst_n), .clk_en(1'b1), .host_pins(pins), .comp_out(comp_out),
    .sample_hold(hold), .dac_code(dac_code), .busy_n(busy_n), .result_bus(result_bus),
    .result_bus_oe(oe), .pwr_mode(pwr_mode), .wake_ready(wake_ready));
  sar_cmp_model u_cmp (.dac_code(dac_code), .level(level), .comp_out(comp_out));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ==========================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc

  task automatic pulse();
    pins.conv_start_n = 1'b0;
    cyc(3);
    pins.conv_start_n = 1'b1;
  endtask : pulse

  task automatic convert(input logic [15:0] v);
    int i;
    level = v;
    exp_q.push_back(v);
    pulse();
    for (i = 0; i < 8 && busy_n; i++) cyc(1);
    chk(16'(hold), 16'h0000);
    cyc(1);
    pulse();
    for (i = 0; i < 200 && !busy_n; i++) cyc(1);
    last_res = v;
    cyc(2);
    chk(16'(hold), 16'h0001);
  endtask : convert

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  // ==========================================
  // result monitor
  always @(negedge core_clk) begin
    busy_q <= busy_n;
    if (rst_n && busy_n === 1'b1 && busy_q === 1'b0) begin
      chk(result_bus, exp_q.size() ? exp_q.pop_front() : ~result_bus);
    end
  end

  initial begin
    cyc(20000);
    err_total++;
    $display("mismatch at %0t: watchdog", $time);
    close_out();
  end

  initial begin
    pins = '1;
    level = 16'h0000;
    rst_n = 1'b0;
    busy_q = 1'b1;
    seed = 32'h0000_002f;
    err_total = 0;
    n_checks = 0;
    cyc(8);
    rst_n = 1'b1;
    cyc(2);
    chk(result_bus, 16'h0000);
    pins.chip_sel_n = 1'b0;
    cyc(2);
    convert(16'h8000);
    convert(16'h7fff);
    convert(16'h0000);
    convert(16'hffff);
    pins.read_n = 1'b0;
    repeat (6) begin
      seed = xs(seed);
      convert(seed[15:0]);
    end
    chk(oe, 1'b1);
    chk(result_bus, last_res);
    $display("end conversions and read");
    pins.chip_sel_n = 1'b1;
    cyc(4);
    chk(oe, 1'b0);
    pulse();
    cyc(6);
    chk(busy_n, 1'b1);
    pins.read_n = 1'b1;
    pins.chip_sel_n = 1'b0;
    pins.power_down_n = 1'b0;
    cyc(5);
    chk(pwr_mode, PWR_NAP);
    pulse();
    cyc(6);
    chk(busy_n, 1'b1);
    pins.chip_sel_n = 1'b1;
    cyc(5);
    chk(pwr_mode, PWR_SLEEP);
    pins.power_down_n = 1'b1;
    pins.chip_sel_n = 1'b0;
    cyc(5);
    chk(wake_ready, 1'b0);
    cyc(22);
    chk(wake_ready, 1'b1);
    chk(pwr_mode, PWR_ACTIVE);
    convert(16'h1234);
    chk(16'(exp_q.size()), 16'h0000);
    $display("end power modes");
    close_out();
  end
endmodule : tb_sar_adc_parallel_control
